// file: src/msdec_pkg.sv
// constants, field layout and carrier types for the media surface descriptor decoder
// assumes one engine clock; descriptor dwords arrive already fetched from memory
package msdec_pkg;

  // dword 1 field positions
  localparam int HEIGHT_LSB = 19;
  localparam int WIDTH_LSB = 6;
  localparam int SITING_LSB = 0;
  // dword 2 field positions
  localparam int FORMAT_LSB = 28;
  localparam int INTERLEAVE_BIT = 27;
  localparam int PITCH_LSB = 3;
  localparam int HALF_PITCH_BIT = 2;
  localparam int TILED_BIT = 1;
  localparam int WALK_BIT = 0;
  // dwords 3 and 4 offset positions
  localparam int XOFF_LSB = 16;
  localparam int YOFF_LSB = 0;
  // sampler-state dword 0 positions
  localparam int SAMP_DISABLE_BIT = 31;
  localparam int SAMP_PRECLAMP_BIT = 28;

  // sampler array geometry: 16 entries, each 4 dwords (16 bytes)
  localparam int SAMP_ENTRIES = 16;
  localparam int SAMP_STRIDE_DW = 4;
  localparam logic [31:0] SAMP_STRIDE_BYTES = 32'h0000_0010;

  // value forced on every channel of a disabled sampler
  localparam logic [31:0] SAMP_FORCE_VALUE = 32'h0000_0000;

  // reset value of every decoded field
  localparam logic [31:0] DECODE_RESET = 32'h0000_0000;

  // surface format codes
  localparam logic [3:0] packed_luma_chroma_order0 = 4'h0;
  localparam logic [3:0] packed_luma_chroma_order1 = 4'h1;
  localparam logic [3:0] packed_luma_chroma_order2 = 4'h2;
  localparam logic [3:0] packed_luma_chroma_order3 = 4'h3;
  localparam logic [3:0] planar_quarter_chroma_8bit = 4'h4;
  localparam logic [3:0] planar_quarter_horiz_chroma_8bit = 4'h5;
  localparam logic [3:0] planar_half_chroma_8bit = 4'h6;
  localparam logic [3:0] denoise_statistics_format = 4'h7;
  localparam logic [3:0] rgb10_a2_format = 4'h8;
  localparam logic [3:0] rgb8_a8_format = 4'h9;
  localparam logic [3:0] chroma_pair_format = 4'ha;
  localparam logic [3:0] chroma_single_format = 4'hb;
  localparam logic [3:0] luma_only_8bit = 4'hc;
  localparam logic [3:0] first_reserved_format = 4'hd;

  // lookup table choice per output channel, bit order {a, b, g, r}; 1 selects table 1
  localparam logic [3:0] LUT_SEL_COLOR = 4'h5;
  localparam logic [3:0] LUT_SEL_LUMA = 4'h0;

  typedef enum logic {tile_walk_x_major_a, tile_walk_y_major_b} msdec_walk_t;

  typedef struct packed {
    logic [31:0] dw4;
    logic [31:0] dw3;
    logic [31:0] dw2;
    logic [31:0] dw1;
    logic [31:0] dw0;
  } msdec_desc_t;

  typedef struct packed {
    logic planar;
    logic packed_yc;
    logic quarter;
    logic even_x;
    logic invalid;
    logic [3:0] lut_sel;
  } msdec_class_t;

  typedef struct packed {
    logic [31:0] base;
    logic [13:0] height;
    logic [13:0] width;
    logic [1:0] siting;
    logic [3:0] format;
    msdec_class_t cls;
    logic interleave;
    logic [17:0] pitch;
    logic [17:0] chroma_pitch;
    logic tiled;
    msdec_walk_t walk;
    logic [12:0] cb_x;
    logic [12:0] cb_y;
    logic [12:0] cr_x;
    logic [12:0] cr_y;
    logic cr_used;
    logic offset_err;
  } msdec_surf_t;

  typedef struct packed {
    logic [31:0] addr;
    logic disable_smp;
    logic preclamp;
  } msdec_samp_t;

endpackage

// file: src/msdec_format.sv
// surface format classifier: splits the 4-bit format code into planar, packed and invalid
// purely combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module msdec_format (
  // format code in
  input wire logic [3:0] format,
  // classification out
  output msdec_pkg::msdec_class_t cls
);
  import msdec_pkg::*;

  wire is_packed = (format <= packed_luma_chroma_order3);
  wire is_planar = (format == planar_quarter_chroma_8bit) ||
                   (format == planar_quarter_horiz_chroma_8bit) ||
                   (format == planar_half_chroma_8bit);
  // RULE_24 reserved codes
  wire is_reserved = (format >= first_reserved_format);
  // RULE_17 even column planes
  wire needs_even_x = (format == planar_quarter_chroma_8bit) ||
                      (format == planar_half_chroma_8bit);

  assign cls.planar = is_planar;
  assign cls.packed_yc = is_packed;
  assign cls.quarter = (format == planar_quarter_chroma_8bit);
  assign cls.even_x = needs_even_x;
  assign cls.invalid = is_reserved;
  // RULE_08 luma on table 0
  assign cls.lut_sel = (format == luma_only_8bit) ? LUT_SEL_LUMA : LUT_SEL_COLOR;

endmodule
`default_nettype wire

// file: src/msdec_sampler.sv
// first sampler-state dword decoder with array indexing and channel forcing
// assumes the caller presents the array base and entry index with the state dword
`timescale 1ns/100ps
`default_nettype none
module msdec_sampler (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // sampler request
  input wire logic samp_valid,
  input wire logic [31:0] samp_array_base,
  input wire logic [3:0] samp_index,
  input wire logic [31:0] samp_dw0,
  input wire logic [31:0] texel_in,
  // decoded sampler
  output logic samp_ready,
  output msdec_pkg::msdec_samp_t samp,
  output logic [31:0] texel_out
);
  import msdec_pkg::*;

  // RULE_21 entry stride
  wire [31:0] entry_offset = {24'h00_0000, samp_index, 4'h0};
  wire [31:0] next_addr = samp_array_base + entry_offset;
  wire next_disable = samp_dw0[SAMP_DISABLE_BIT];
  // RULE_23 pre-clamp select
  wire select_c = samp_dw0[SAMP_PRECLAMP_BIT];
  // RULE_22 forced channel value
  wire [31:0] next_texel = next_disable ? SAMP_FORCE_VALUE : texel_in;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      samp <= '0;
      texel_out <= DECODE_RESET;
      samp_ready <= 1'b0;
    end else if (ce) begin
      samp_ready <= samp_valid;
      if (samp_valid) begin
        samp <= '{addr: next_addr, disable_smp: next_disable, preclamp: select_c};
        texel_out <= next_texel;
      end
    end
  end

endmodule
`default_nettype wire

// file: src/msdec_top.sv
// media surface descriptor decoder: turns a five-dword surface descriptor and the first
// sampler-state dword into registered fields for the deinterlace and 8x8 sampling paths
// assumes descriptors arrive as whole five-dword words with a one-cycle valid strobe
//
// Functional notes
// RULE_01: dword 0 bits 31:0 give the surface byte base, luma plane for planar.
// RULE_02: software aligns tiled base to 4KB; base itself is never tiled.
// RULE_03: height is dword 1 bits 31:19 plus one, 1 to 8192 rows.
// RULE_04: width is dword 1 bits 18:6 plus one, 1 to 8192 pixels.
// RULE_05: software keeps width even or multiple of four, within pitch.
// RULE_06: dword 1 bits 1:0 give chroma vertical siting, only for planar 4:2:0.
// RULE_07: dword 2 bits 31:28 select the surface format; 13 to 15 reserved.
// RULE_08: luma and green use table 0; red, blue, chroma use table 1.
// RULE_09: dword 2 bit 27 fetches both chroma from one interleaved plane.
// RULE_10: pitch is dword 2 bits 19:3 plus one bytes.
// RULE_11: software keeps pitch inside the range for its surface kind.
// RULE_12: dword 2 bit 2 halves the pitch for planar chroma planes.
// RULE_13: software makes tiled pitch a tile-width multiple, doubled with half pitch.
// RULE_14: dword 2 bit 1 set means tiled, clear means linear.
// RULE_15: dword 2 bit 0 picks Y-major walk; ignored when linear.
// RULE_16: software invalidates caches when tiling or walk changes.
// RULE_17: dword 3 bits 28:16 give blue or interleaved plane column offset, even.
// RULE_18: dword 3 bits 12:0 give blue or interleaved plane row offset, even.
// RULE_19: dword 4 red plane offsets apply only to planar without interleave.
// RULE_20: software writes zero to reserved descriptor bits.
// RULE_21: sampler state is up to sixteen entries, four dwords apart.
// RULE_22: sampler-state bit 31 disables the sampler and forces outputs.
// RULE_23: sampler-state bit 28 enables LOD pre-clamp before mag/min choice.
// RULE_24: reserved format codes are flagged invalid, no defined data.
`timescale 1ns/100ps
`default_nettype none
module msdec_top (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // descriptor request
  input wire logic desc_valid,
  input wire msdec_pkg::msdec_desc_t desc,
  // decoded surface
  output logic surf_valid,
  output msdec_pkg::msdec_surf_t surf,
  // sampler request
  input wire logic samp_valid,
  input wire logic [31:0] samp_array_base,
  input wire logic [3:0] samp_index,
  input wire logic [31:0] samp_dw0,
  input wire logic [31:0] texel_in,
  // decoded sampler
  output logic samp_ready,
  output msdec_pkg::msdec_samp_t samp,
  output logic [31:0] texel_out
);
  import msdec_pkg::*;

  msdec_class_t cls;

  // RULE_07 format field
  wire [3:0] fmt = desc.dw2[FORMAT_LSB +: 4];

  msdec_format u_format (
    .format(fmt),
    .cls(cls)
  );

  // RULE_01 base address
  wire [31:0] base = desc.dw0;
  // RULE_03 height plus one
  wire [13:0] height = {1'b0, desc.dw1[HEIGHT_LSB +: 13]} + 14'h0001;
  // RULE_04 width plus one
  wire [13:0] width = {1'b0, desc.dw1[WIDTH_LSB +: 13]} + 14'h0001;
  // RULE_06 siting only for 4:2:0
  wire [1:0] siting = cls.quarter ? desc.dw1[SITING_LSB +: 2] : 2'h0;
  // RULE_09 interleave only when planar
  wire interleave = cls.planar & desc.dw2[INTERLEAVE_BIT];
  // RULE_10 pitch plus one
  wire [17:0] pitch = {1'b0, desc.dw2[PITCH_LSB +: 17]} + 18'h00001;
  // RULE_12 halved chroma pitch
  wire half_pitch = cls.planar & desc.dw2[HALF_PITCH_BIT];
  wire [17:0] chroma_pitch = half_pitch ? {1'b0, pitch[17:1]} : pitch;
  // RULE_14 tiled flag
  wire tiled = desc.dw2[TILED_BIT];
  // RULE_15 walk ignored when linear
  wire walk_y = tiled & desc.dw2[WALK_BIT];
  wire [12:0] cb_x = cls.planar ? desc.dw3[XOFF_LSB +: 13] : 13'h0000;
  wire [12:0] cb_y = cls.planar ? desc.dw3[YOFF_LSB +: 13] : 13'h0000;
  // RULE_19 red plane offsets gated
  wire cr_used = cls.planar & ~interleave;
  wire [12:0] cr_x = cr_used ? desc.dw4[XOFF_LSB +: 13] : 13'h0000;
  wire [12:0] cr_y = cr_used ? desc.dw4[YOFF_LSB +: 13] : 13'h0000;
  // RULE_17 odd column flagged
  wire odd_x = cls.even_x & (cb_x[0] | cr_x[0]);
  // RULE_18 odd row flagged
  wire odd_y = cb_y[0] | cr_y[0];

  msdec_surf_t next_surf;
  assign next_surf = '{base: base, height: height, width: width, siting: siting,
                       format: fmt, cls: cls, interleave: interleave, pitch: pitch,
                       chroma_pitch: chroma_pitch, tiled: tiled,
                       walk: msdec_walk_t'(walk_y), cb_x: cb_x, cb_y: cb_y,
                       cr_x: cr_x, cr_y: cr_y, cr_used: cr_used,
                       offset_err: odd_x | odd_y};

  // decoded fields stay until the next descriptor, so the sampling path may read them late
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      surf <= '0;
      surf_valid <= 1'b0;
    end else if (ce) begin
      surf_valid <= desc_valid;
      if (desc_valid) begin
        surf <= next_surf;
      end
    end
  end

  msdec_sampler u_sampler (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .samp_valid(samp_valid),
    .samp_array_base(samp_array_base),
    .samp_index(samp_index),
    .samp_dw0(samp_dw0),
    .texel_in(texel_in),
    .samp_ready(samp_ready),
    .samp(samp),
    .texel_out(texel_out)
  );

  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // checks assume ce held high across the window they span
  property p_take(logic cond);
    ce && desc_valid && cond ##1 ce |-> 1'b1;
  endproperty

  height_span_a: assert property ( // RULE_03
    ce && desc_valid |=> surf.height == $past(desc.dw1[31:19]) + 14'h0001)
    else $error("height is not field plus one");

  width_span_a: assert property ( // RULE_04
    ce && desc_valid |=> surf.width == $past(desc.dw1[18:6]) + 14'h0001)
    else $error("width is not field plus one");

  base_addr_a: assert property ( // RULE_01
    ce && desc_valid |=> surf_valid && surf.base == $past(desc.dw0))
    else $error("base address not captured");

  siting_gate_a: assert property ( // RULE_06
    surf_valid && surf.format != planar_quarter_chroma_8bit |-> surf.siting == 2'h0)
    else $error("siting passed for a non 4:2:0 format");

  pitch_half_a: assert property ( // RULE_12
    ce && desc_valid && desc.dw2[2] && desc.dw2[31:28] == planar_half_chroma_8bit
    |=> surf.chroma_pitch == {1'b0, surf.pitch[17:1]})
    else $error("chroma pitch not halved");

  pitch_plus_a: assert property ( // RULE_10
    ce && desc_valid |=> surf.pitch == $past(desc.dw2[19:3]) + 18'h00001)
    else $error("pitch is not field plus one");

  walk_linear_a: assert property ( // RULE_15
    surf_valid && !surf.tiled |-> surf.walk == tile_walk_x_major_a)
    else $error("tile walk reported on a linear surface");

  cr_plane_a: assert property ( // RULE_19
    surf_valid && (surf.interleave || !surf.cls.planar) |-> !surf.cr_used &&
    surf.cr_x == 13'h0000 && surf.cr_y == 13'h0000)
    else $error("red plane offsets used without a separate plane");

  interleave_a: assert property ( // RULE_09
    surf_valid && surf.interleave |-> surf.cls.planar)
    else $error("interleave set on a non planar format");

  reserved_fmt_a: assert property ( // RULE_24
    ce && desc_valid && desc.dw2[31:28] >= 4'hd |=> surf.cls.invalid)
    else $error("reserved format not flagged");

  lut_route_a: assert property ( // RULE_08
    surf_valid |-> surf.cls.lut_sel[1] == 1'b0 && surf.cls.lut_sel[3] == 1'b0)
    else $error("green or alpha channel routed to table 1");

  samp_force_a: assert property ( // RULE_22
    ce && samp_valid && samp_dw0[31] |=> samp_ready && samp.disable_smp &&
    texel_out == SAMP_FORCE_VALUE)
    else $error("disabled sampler did not force its output");

  samp_stride_a: assert property ( // RULE_21
    ce && samp_valid |=> samp.addr == $past(samp_array_base) + {$past(samp_index), 4'h0})
    else $error("sampler entry address off stride");

  preclamp_a: assert property ( // RULE_23
    ce && samp_valid |=> samp.preclamp == $past(samp_dw0[28]))
    else $error("pre-clamp select not captured");

  // own decode of the taken code, so the take checks below do not lean on the classifier
  wire chk_planar = desc.dw2[31:28] inside {4'h4, 4'h5, 4'h6};

  format_take_a: assert property ( // RULE_07
    ce && desc_valid |=> surf.format == $past(desc.dw2[31:28]))
    else $error("format code not captured");

  planar_class_a: assert property ( // RULE_07
    surf_valid |-> surf.cls.planar == (surf.format inside {4'h4, 4'h5, 4'h6}))
    else $error("planar class does not match the format code");

  packed_class_a: assert property ( // RULE_07
    surf_valid |-> surf.cls.packed_yc == (surf.format < 4'h4))
    else $error("packed class does not match the format code");

  legal_fmt_a: assert property ( // RULE_24
    surf_valid && surf.format < 4'hd |-> !surf.cls.invalid)
    else $error("legal format flagged invalid");

  // RULE_08 per-channel table: red (bit 0) and blue (bit 2) on table 1 unless luma only
  for (genvar ch = 0; ch < 4; ch++) begin : g_lut
    localparam logic ON_T1 = (ch == 0) || (ch == 2);
    lut_chan_a: assert property ( // RULE_08
      surf_valid |-> surf.cls.lut_sel[ch] == (ON_T1 && surf.format != 4'hc))
      else $error("channel routed to the wrong lookup table");
  end

  siting_take_a: assert property ( // RULE_06
    ce && desc_valid && desc.dw2[31:28] == 4'h4 |=> surf.siting == $past(desc.dw1[1:0]))
    else $error("siting not captured for 4:2:0");

  interleave_take_a: assert property ( // RULE_09
    ce && desc_valid && chk_planar |=> surf.interleave == $past(desc.dw2[27]))
    else $error("interleave not captured on a planar format");

  pitch_full_a: assert property ( // RULE_12
    ce && desc_valid && !(chk_planar && desc.dw2[2]) |=> surf.chroma_pitch == surf.pitch)
    else $error("chroma pitch changed without a planar half-pitch request");

  tiled_take_a: assert property ( // RULE_14
    ce && desc_valid |=> surf.tiled == $past(desc.dw2[1]))
    else $error("tiled flag not captured");

  walk_tiled_a: assert property ( // RULE_15
    ce && desc_valid && desc.dw2[1] |=> logic'(surf.walk) == $past(desc.dw2[0]))
    else $error("tile walk not captured on a tiled surface");

  cb_col_a: assert property ( // RULE_17
    ce && desc_valid && chk_planar |=> surf.cb_x == $past(desc.dw3[28:16]))
    else $error("blue plane column offset not captured");

  cb_row_a: assert property ( // RULE_18
    ce && desc_valid && chk_planar |=> surf.cb_y == $past(desc.dw3[12:0]))
    else $error("blue plane row offset not captured");

  cb_unused_a: assert property ( // RULE_17
    surf_valid && !surf.cls.planar |-> surf.cb_x == 13'h0000 && surf.cb_y == 13'h0000)
    else $error("blue plane offsets reported on a non planar format");

  cr_take_a: assert property ( // RULE_19
    ce && desc_valid && chk_planar && !desc.dw2[27] |=> surf.cr_used &&
    surf.cr_x == $past(desc.dw4[28:16]) && surf.cr_y == $past(desc.dw4[12:0]))
    else $error("red plane offsets not captured");

  odd_row_a: assert property ( // RULE_18
    surf_valid && (surf.cb_y[0] || surf.cr_y[0]) |-> surf.offset_err)
    else $error("odd chroma row offset not flagged");

  odd_col_a: assert property ( // RULE_17
    surf_valid && surf.format inside {4'h4, 4'h6} && (surf.cb_x[0] || surf.cr_x[0])
    |-> surf.offset_err)
    else $error("odd chroma column offset not flagged");

  even_ok_a: assert property ( // RULE_18
    surf_valid && !surf.cb_x[0] && !surf.cr_x[0] && !surf.cb_y[0] && !surf.cr_y[0]
    |-> !surf.offset_err)
    else $error("even chroma offsets flagged");

  valid_pulse_a: assert property ( // RULE_07
    ce && !desc_valid |=> !surf_valid)
    else $error("surface valid without a taken descriptor");

  surf_hold_a: assert property ( // RULE_07
    !(ce && desc_valid) |=> $stable(surf))
    else $error("decoded surface changed without a descriptor");

  // a low enable must freeze every answer, whatever the request pins do
  freeze_a: assert property ( // RULE_07
    !ce |=> $stable(surf_valid) && $stable(surf) && $stable(samp_ready) &&
    $stable(samp) && $stable(texel_out))
    else $error("outputs moved while the clock enable was low");

  samp_pulse_a: assert property ( // RULE_21
    ce && !samp_valid |=> !samp_ready)
    else $error("sampler ready without a taken request");

  samp_hold_a: assert property ( // RULE_22
    !(ce && samp_valid) |=> $stable(samp) && $stable(texel_out))
    else $error("sampler answer changed without a request");

  texel_pass_a: assert property ( // RULE_22
    ce && samp_valid && !samp_dw0[31] |=> !samp.disable_smp &&
    texel_out == $past(texel_in))
    else $error("enabled sampler did not pass its texel");

  planar_desc_c: cover property (p_take(desc.dw2[31:28] == planar_quarter_chroma_8bit));
  interleave_desc_c: cover property (p_take(desc.dw2[27] && desc.dw2[31:28] == 4'h4));
  tiled_y_c: cover property (p_take(desc.dw2[1] && desc.dw2[0]));
  samp_disabled_c: cover property (ce && samp_valid && samp_dw0[31]);

endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the surface descriptor decoder, driving its ports directly
// assumes one engine clock and a one-cycle registered answer on both request groups
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import msdec_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic desc_valid = 1'b0;
  msdec_desc_t desc = '0;
  logic surf_valid;
  msdec_surf_t surf;
  logic samp_valid = 1'b0;
  logic [31:0] samp_array_base = 32'h0;
  logic [3:0] samp_index = 4'h0;
  logic [31:0] samp_dw0 = 32'h0;
  logic [31:0] texel_in = 32'h0;
  logic samp_ready;
  msdec_samp_t samp;
  logic [31:0] texel_out;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  msdec_top uut (.clk(clk), .rstn(rstn), .ce(ce), .desc_valid(desc_valid), .desc(desc),
    .surf_valid(surf_valid), .surf(surf), .samp_valid(samp_valid),
    .samp_array_base(samp_array_base), .samp_index(samp_index), .samp_dw0(samp_dw0),
    .texel_in(texel_in), .samp_ready(samp_ready), .samp(samp), .texel_out(texel_out));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic do_desc(input msdec_desc_t d);
    logic [3:0] f;
    logic pl;
    logic il;
    logic [17:0] p;
    logic [12:0] cbx, cby, crx, cry;
    logic oe;
    f = d.dw2[31:28];
    pl = (f == 4'h4) || (f == 4'h5) || (f == 4'h6);
    il = pl & d.dw2[27];
    p = {1'b0, d.dw2[19:3]} + 18'h1;
    cbx = pl ? d.dw3[28:16] : 13'h0;
    cby = pl ? d.dw3[12:0] : 13'h0;
    crx = (pl & !il) ? d.dw4[28:16] : 13'h0;
    cry = (pl & !il) ? d.dw4[12:0] : 13'h0;
    oe = (((f == 4'h4) || (f == 4'h6)) & (cbx[0] | crx[0])) | cby[0] | cry[0];
    desc = d;
    desc_valid = 1'b1;
    @(negedge clk);
    desc_valid = 1'b0;
    chk("surf_valid", surf_valid, 32'h1);
    chk("base", surf.base, d.dw0);
    chk("height", surf.height, {1'b0, d.dw1[31:19]} + 14'h1);
    chk("width", surf.width, {1'b0, d.dw1[18:6]} + 14'h1);
    chk("siting", surf.siting, (f == 4'h4) ? d.dw1[1:0] : 2'h0);
    chk("format", surf.format, f);
    chk("planar", surf.cls.planar, pl);
    chk("packed", surf.cls.packed_yc, f < 4'h4);
    chk("invalid", surf.cls.invalid, f >= 4'hd);
    chk("lut_sel", surf.cls.lut_sel, (f == 4'hc) ? LUT_SEL_LUMA : LUT_SEL_COLOR);
    chk("interleave", surf.interleave, il);
    chk("pitch", surf.pitch, p);
    chk("chroma_pitch", surf.chroma_pitch, (pl & d.dw2[2]) ? p >> 1 : p);
    chk("tiled", surf.tiled, d.dw2[1]);
    chk("walk", surf.walk, d.dw2[1] & d.dw2[0]);
    chk("cb_x", surf.cb_x, cbx);
    chk("cb_y", surf.cb_y, cby);
    chk("cr_used", surf.cr_used, pl & !il);
    chk("cr_x", surf.cr_x, crx);
    chk("cr_y", surf.cr_y, cry);
    chk("offset_err", surf.offset_err, oe);
    chk("quarter", surf.cls.quarter, f == 4'h4);
    chk("even_x", surf.cls.even_x, (f == 4'h4) || (f == 4'h6));
    @(negedge clk);
    chk("surf_valid low", surf_valid, 32'h0);
  endtask

  task automatic do_samp(input logic [31:0] b, input logic [3:0] ix, input logic [31:0] w,
    input logic [31:0] t);
    samp_array_base = b;
    samp_index = ix;
    samp_dw0 = w;
    texel_in = t;
    samp_valid = 1'b1;
    @(negedge clk);
    samp_valid = 1'b0;
    texel_in = ~t;
    chk("samp_ready", samp_ready, 32'h1);
    chk("samp addr", samp.addr, b + {24'h0, ix, 4'h0});
    chk("disable", samp.disable_smp, w[31]);
    chk("preclamp", samp.preclamp, w[28]);
    chk("texel_out", texel_out, w[31] ? SAMP_FORCE_VALUE : t);
    @(negedge clk);
    chk("samp_ready low", samp_ready, 32'h0);
    chk("texel held", texel_out, w[31] ? SAMP_FORCE_VALUE : t);
  endtask

  initial begin
    msdec_desc_t d;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    chk("reset surf_valid", surf_valid, 32'h0);
    chk("reset base", surf.base, DECODE_RESET);
    // every format code, mixing tiling, walk, interleave and odd offsets
    // fresh base each surface
    for (int i = 0; i < 16; i++) begin
      d.dw0 = 32'h1000_0000 + 32'(i * 4096);
      d.dw1 = {13'(i * 3), 13'(1023 - 4 * i), 4'h0, 2'(i)};
      d.dw2 = {4'(i), i[0], 7'h0, 17'((i + 1) * 4096 - 1), i[1], i[2], i[0]};
      d.dw3 = {3'h0, 13'(i), 3'h0, 13'(i * 2)};
      d.dw4 = {3'h0, 13'(i + 1), 3'h0, 13'(i + 2)};
      do_desc(d);
    end
    // field extremes: largest size and pitch, then smallest
    d.dw0 = 32'h2000_0000;
    d.dw1 = 32'hffff_ffc3;
    d.dw2 = {4'h4, 1'b1, 7'h0, 17'h1ffff, 3'b011};
    do_desc(d);
    d.dw0 = 32'h3000_0000;
    d.dw1 = 32'h0;
    d.dw2 = {4'hc, 1'b0, 7'h0, 17'h0, 3'b100};
    do_desc(d);
    // back-to-back descriptors keep the strobe high two cycles
    // pitch fits 4-byte pixel
    d.dw2[31:28] = 4'h9;
    d.dw2[19:3] = 17'h00003;
    desc = d;
    desc_valid = 1'b1;
    @(negedge clk);
    desc.dw2[31:28] = 4'hc;
    chk("b2b first", surf.format, 4'h9);
    @(negedge clk);
    desc_valid = 1'b0;
    chk("b2b valid", surf_valid, 32'h1);
    chk("b2b second", surf.format, 4'hc);
    @(negedge clk);
    chk("b2b drop", surf_valid, 32'h0);
    // a held clock enable must ignore a pending descriptor
    ce = 1'b0;
    desc.dw2[31:28] = 4'h8;
    desc_valid = 1'b1;
    repeat (3) @(negedge clk);
    chk("frozen valid", surf_valid, 32'h0);
    chk("frozen format", surf.format, 4'hc);
    desc_valid = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    // entries 0, 5, 10, 15 with each disable and pre-clamp setting
    for (int k = 0; k < 4; k++) begin
      do_samp(32'h0004_0000 + 32'(k * 64), 4'(k * 5), {k[1], 2'b0, k[0], 28'h0},
        32'hcafe_0000 + 32'(k));
    end
    // mid-run reset clears both answers; a request follows right after release
    rstn = 1'b0;
    @(negedge clk);
    chk("mid reset valid", surf_valid, 32'h0);
    chk("mid reset base", surf.base, DECODE_RESET);
    chk("mid reset addr", samp.addr, DECODE_RESET);
    chk("mid reset texel", texel_out, DECODE_RESET);
    rstn = 1'b1;
    do_desc(d);
    test_done();
  end
endmodule
`default_nettype wire
